// file: design/cpu_exec_pkg.sv
// Constants, types and decode helpers for the instruction-subset executor.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
`default_nettype none
package cpu_exec_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned PC_W = 15;

    // Register byte offsets
    localparam logic [7:0] OFF_INSTR  = 8'h00;
    localparam logic [7:0] OFF_WREG   = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PC     = 8'h0C;
    localparam logic [7:0] OFF_PCH    = 8'h10;
    localparam logic [7:0] OFF_TOS    = 8'h14;
    localparam logic [7:0] OFF_FADDR  = 8'h18;
    localparam logic [7:0] OFF_FDATA  = 8'h1C;
    localparam logic [7:0] OFF_CYCLES = 8'h20;

    // Status register bit positions
    localparam int unsigned ST_Z_BIT    = 0;
    localparam int unsigned ST_PD_BIT   = 3;
    localparam int unsigned ST_TO_BIT   = 4;
    localparam int unsigned ST_BUSY_BIT = 5;
    localparam int unsigned ST_SKIP_BIT = 6;

    // Instruction word fields
    localparam int unsigned F_LSB   = 0;
    localparam int unsigned D_BIT   = 7;
    localparam int unsigned OPC_LSB = 8;

    // Opcode field values (bits 13:8)
    localparam logic [5:0] OPC_WDT  = 6'h01;
    localparam logic [5:0] OPC_CALL = 6'h02;
    localparam logic [5:0] OPC_CLEAR_WORKING_REG_OP = 6'h03;
    localparam logic [5:0] OPC_CLEAR_FILE_OP = 6'h04;
    localparam logic [5:0] OPC_COMPLEMENT_FILE_OP = 6'h05;
    localparam logic [5:0] OPC_DECREMENT_FILE_OP = 6'h06;
    localparam logic [5:0] OPC_DSZ  = 6'h07;

    // Reset values and cycle counts
    localparam logic [PC_W-1:0] RST_PC  = 15'h0000;
    localparam logic [7:0]      RST_W   = 8'h00;
    localparam logic [6:0]      RST_PCH = 7'h00;
    localparam logic [1:0]      CYC_ONE = 2'h1;
    localparam logic [1:0]      CYC_TWO = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_FETCH  = 4'h2,
        ST_EXEC   = 4'h4,
        ST_SECOND = 4'h8
    } state_t;

    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_WDT  = 4'h1,
        OP_CALL = 4'h2,
        OP_CLEAR_WORKING_REG_OP = 4'h3,
        OP_CLEAR_FILE_OP = 4'h4,
        OP_COMPLEMENT_FILE_OP = 4'h5,
        OP_DECREMENT_FILE_OP = 4'h6,
        OP_DSZ  = 4'h7
    } op_t;

    function automatic op_t decode_op(input logic [INSTR_W-1:0] instr);
        logic [5:0] opc;
        opc = instr[INSTR_W-1:OPC_LSB];
        case (opc)
            OPC_WDT:  decode_op = OP_WDT;
            OPC_CALL: decode_op = OP_CALL;
            OPC_CLEAR_WORKING_REG_OP: decode_op = OP_CLEAR_WORKING_REG_OP;
            OPC_CLEAR_FILE_OP: decode_op = OP_CLEAR_FILE_OP;
            OPC_COMPLEMENT_FILE_OP: decode_op = OP_COMPLEMENT_FILE_OP;
            OPC_DECREMENT_FILE_OP: decode_op = OP_DECREMENT_FILE_OP;
            OPC_DSZ:  decode_op = OP_DSZ;
            default:  decode_op = OP_NOP;
        endcase
    endfunction

    function automatic logic [31:0] strobe_merge(input logic [31:0] old_val,
                                                 input logic [31:0] new_val,
                                                 input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        strobe_merge = res;
    endfunction

endpackage
`default_nettype wire

// file: design/cpu_instr_subset_exec.sv
// Executor for a subset of an 8-bit core's instructions, driven over AXI4-Lite.
// Assumes one clock; watchdog and sleep events arrive as same-clock pulses.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_subset_exec
    import cpu_exec_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_core_en,
    input  wire logic              i_wdt_expired,
    input  wire logic              i_sleep_entered,
    input  wire logic              i_awvalid,
    output var  logic              o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_wvalid,
    output var  logic              o_wready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    output var  logic              o_bvalid,
    input  wire logic              i_bready,
    output var  logic [1:0]        o_bresp,
    input  wire logic              i_arvalid,
    output var  logic              o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    output var  logic              o_rvalid,
    input  wire logic              i_rready,
    output var  logic [31:0]       o_rdata,
    output var  logic [1:0]        o_rresp,
    output var  logic              o_wdt_clear,
    output var  logic              o_stack_push,
    output var  logic [PC_W-1:0]   o_stack_data,
    output var  logic [PC_W-1:0]   o_pc,
    output var  logic [7:0]        o_w,
    output var  logic              o_zero,
    output var  logic              o_to_n,
    output var  logic              o_pd_n,
    output var  logic              o_busy
);

    state_t               state;
    state_t               next_state;
    logic [INSTR_W-1:0]   instr_q;
    logic [6:0]           pch;
    logic [6:0]           faddr;
    logic                 skip_pending;
    logic [1:0]           last_cycles;
    logic                 aw_got;
    logic                 w_got;
    logic [ADDR_W-1:0]    awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic [7:0]           mem_rdata_a;
    logic [7:0]           mem_rdata_b;

    // Bus handshakes
    wire logic aw_hs = i_awvalid & o_awready;
    wire logic w_hs = i_wvalid & o_wready;
    wire logic ar_hs = i_arvalid & o_arready;
    wire logic wr_fire = aw_got & w_got & ~o_bvalid;
    wire logic next_aw_got = aw_hs | (aw_got & ~wr_fire);
    wire logic next_w_got = w_hs | (w_got & ~wr_fire);
    wire logic next_bvalid = wr_fire | (o_bvalid & ~i_bready);
    wire logic next_rvalid = ar_hs | (o_rvalid & ~i_rready);

    // Write decode; writes while an instruction runs are dropped
    wire logic idle = (state == ST_IDLE);
    wire logic wr_ok = wr_fire & idle;
    wire logic wr_instr = wr_ok & (awaddr_q == OFF_INSTR);
    wire logic wr_wreg = wr_ok & (awaddr_q == OFF_WREG);
    wire logic wr_status = wr_ok & (awaddr_q == OFF_STATUS);
    wire logic wr_pc = wr_ok & (awaddr_q == OFF_PC);
    wire logic wr_pch = wr_ok & (awaddr_q == OFF_PCH);
    wire logic wr_faddr = wr_ok & (awaddr_q == OFF_FADDR);
    wire logic wr_fdata = wr_ok & (awaddr_q == OFF_FDATA);
    wire logic wr_hit = (awaddr_q <= OFF_CYCLES) & (awaddr_q[1:0] == 2'h0);
    wire logic [31:0] merged = strobe_merge(32'h0000_0000, wdata_q, wstrb_q);
    wire logic discard = wr_instr & skip_pending;

    // Instruction fields and execution
    wire op_t        op = decode_op(instr_q);
    wire logic [6:0] f_addr = instr_q[F_LSB +: 7];
    wire logic       dest_file = instr_q[D_BIT];
    wire logic       ex_fire = i_core_en & (state == ST_EXEC);
    wire logic       arith = (op == OP_COMPLEMENT_FILE_OP) | (op == OP_DECREMENT_FILE_OP) | (op == OP_DSZ);
    wire logic [7:0] dec_res = mem_rdata_a - 8'h01;
    wire logic [7:0] alu_res = (op == OP_COMPLEMENT_FILE_OP) ? ~mem_rdata_a :
                               (op == OP_CLEAR_FILE_OP) ? 8'h00 : dec_res;
    wire logic       res_zero = (alu_res == 8'h00);
    wire logic       skip_taken = (op == OP_DSZ) & res_zero;
    wire logic [PC_W-1:0] pc_next_seq = o_pc + 15'h0001;

    // File write: clear-file always, other results by destination bit, or software when idle
    wire logic ex_we = (op == OP_CLEAR_FILE_OP) | (arith & dest_file);
    wire logic mem_we = (ex_fire & ex_we) | (i_core_en & wr_fdata);
    wire logic [6:0] mem_waddr = ex_fire ? f_addr : faddr;
    wire logic [7:0] mem_wdata = ex_fire ? alu_res : merged[7:0];

    // Read decode
    wire logic [31:0] status_word = {25'h0, skip_pending, ~idle, o_to_n, o_pd_n,
                                     2'h0, o_zero};
    wire logic rd_hit = (i_araddr <= OFF_CYCLES) & (i_araddr[1:0] == 2'h0);
    wire logic [31:0] rd_word =
        (i_araddr == OFF_INSTR)  ? {18'h0, instr_q} :
        (i_araddr == OFF_WREG)   ? {24'h0, o_w} :
        (i_araddr == OFF_STATUS) ? status_word :
        (i_araddr == OFF_PC)     ? {17'h0, o_pc} :
        (i_araddr == OFF_PCH)    ? {25'h0, pch} :
        (i_araddr == OFF_TOS)    ? {17'h0, o_stack_data} :
        (i_araddr == OFF_FADDR)  ? {25'h0, faddr} :
        (i_araddr == OFF_FDATA)  ? {24'h0, mem_rdata_b} :
        (i_araddr == OFF_CYCLES) ? {30'h0, last_cycles} : 32'h0000_0000;

    file_reg_ram u_ram
    (
        .i_core_clk (i_core_clk),
        .i_core_en  (i_core_en),
        .i_we       (mem_we),
        .i_waddr    (mem_waddr),
        .i_wdata    (mem_wdata),
        .i_raddr_a  (f_addr),
        .i_raddr_b  (faddr),
        .o_rdata_a  (mem_rdata_a),
        .o_rdata_b  (mem_rdata_b)
    );

    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:   next_state = (wr_instr & ~skip_pending) ? ST_FETCH : ST_IDLE;
            ST_FETCH:  next_state = ST_EXEC;
            ST_EXEC:   next_state = (op == OP_CALL) ? ST_SECOND : ST_IDLE;
            ST_SECOND: next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
            instr_q <= '0;
            last_cycles <= CYC_ONE;
        end
        else if (i_core_en)
        begin
            state <= next_state;
            o_busy <= (next_state != ST_IDLE);
            if (wr_instr & ~skip_pending)
            begin
                instr_q <= merged[INSTR_W-1:0];
            end
            if (ex_fire)
            begin
                last_cycles <= ((op == OP_CALL) | skip_taken) ? CYC_TWO : CYC_ONE;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_wdt_clear <= 1'b0;
            o_stack_push <= 1'b0;
            o_stack_data <= RST_PC;
        end
        else if (i_core_en)
        begin
            o_wdt_clear <= ex_fire & (op == OP_WDT);
            o_stack_push <= ex_fire & (op == OP_CALL);
            if (ex_fire & (op == OP_CALL))
            begin
                o_stack_data <= pc_next_seq;
            end
        end
    end

    // call target from latch and W
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_pc <= RST_PC;
            pch <= RST_PCH;
            faddr <= 7'h00;
        end
        else if (i_core_en)
        begin
            if (ex_fire & (op == OP_CALL))
                o_pc <= {pch, o_w};
            else if (ex_fire | discard)
                o_pc <= pc_next_seq;
            else if (wr_pc)
                o_pc <= merged[PC_W-1:0];
            if (wr_pch)
                pch <= merged[6:0];
            if (wr_faddr)
                faddr <= merged[6:0];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            o_w <= RST_W;
        else if (i_core_en)
        begin
            if (ex_fire & (op == OP_CLEAR_WORKING_REG_OP))
                o_w <= 8'h00;
            else if (ex_fire & arith & ~dest_file)
                o_w <= alu_res;
            else if (wr_wreg)
                o_w <= merged[7:0];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_zero <= 1'b0;
            skip_pending <= 1'b0;
        end
        else if (i_core_en)
        begin
            if (ex_fire & ((op == OP_CLEAR_FILE_OP) | (op == OP_CLEAR_WORKING_REG_OP)))
                o_zero <= 1'b1;
            else if (ex_fire & ((op == OP_COMPLEMENT_FILE_OP) | (op == OP_DECREMENT_FILE_OP)))
                o_zero <= res_zero;
            else if (wr_status)
                o_zero <= merged[ST_Z_BIT];
            if (ex_fire & skip_taken)
                skip_pending <= 1'b1;
            else if (discard)
                skip_pending <= 1'b0;
        end
    end

    // flags set; a same-cycle event wins
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_to_n <= 1'b1;
            o_pd_n <= 1'b1;
        end
        else if (i_core_en)
        begin
            if (i_wdt_expired)
                o_to_n <= 1'b0;
            else if (ex_fire & (op == OP_WDT))
                o_to_n <= 1'b1;
            if (i_sleep_entered)
                o_pd_n <= 1'b0;
            else if (ex_fire & (op == OP_WDT))
                o_pd_n <= 1'b1;
        end
    end

    // Bus slave; the master must stay idle while the enable is low
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (i_core_en)
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            o_awready <= ~next_aw_got & ~next_bvalid;
            o_wready <= ~next_w_got & ~next_bvalid;
            o_bvalid <= next_bvalid;
            if (aw_hs)
                awaddr_q <= i_awaddr;
            if (w_hs)
            begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (wr_fire)
                o_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end
        else if (i_core_en)
        begin
            o_arready <= ~next_rvalid;
            o_rvalid <= next_rvalid;
            if (ar_hs)
            begin
                o_rdata <= rd_word;
                o_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    AST_WDT_CLEAR: assert property (
        ex_fire && op == OP_WDT |=> o_wdt_clear ##1 (!o_wdt_clear || !i_core_en))
        else $error("watchdog clear not a single pulse");

    AST_WDT_FLAGS: assert property (
        ex_fire && op == OP_WDT && !i_wdt_expired && !i_sleep_entered |=> o_to_n && o_pd_n)
        else $error("watchdog clear did not set flags");

    AST_CALL_PUSH: assert property (
        ex_fire && op == OP_CALL |=> o_stack_push && o_stack_data == $past(pc_next_seq))
        else $error("call pushed wrong return address");

    AST_CALL_TARGET: assert property (
        ex_fire && op == OP_CALL |=> o_pc == {$past(pch), $past(o_w)})
        else $error("call target wrong");

    AST_CALL_TWO: assert property (
        ex_fire && op == OP_CALL |=> state == ST_SECOND && $stable(o_zero))
        else $error("call not two cycles or flag changed");

    AST_COMP_W: assert property (
        ex_fire && op == OP_COMPLEMENT_FILE_OP && !dest_file |=> o_w == ~$past(mem_rdata_a))
        else $error("complement into W wrong");

    AST_CLEAR_FILE_OP_WRITE: assert property (
        ex_fire && op == OP_CLEAR_FILE_OP |-> mem_we && mem_wdata == 8'h00 ##1 o_zero)
        else $error("clear file wrong");

    AST_DEC_W: assert property (
        ex_fire && op == OP_DECREMENT_FILE_OP && !dest_file |=> o_w == $past(mem_rdata_a) - 8'h01)
        else $error("decrement into W wrong");

    AST_CLEAR_WORKING_REG_OP: assert property (
        ex_fire && op == OP_CLEAR_WORKING_REG_OP |=> o_w == 8'h00 && o_zero)
        else $error("clear W wrong");

    AST_DSZ_FLAGS: assert property (
        ex_fire && op == OP_DSZ |=> $stable(o_zero))
        else $error("decrement-skip changed zero flag");

    AST_DSZ_SKIP: assert property (
        ex_fire && op == OP_DSZ |=> skip_pending == ($past(mem_rdata_a) == 8'h01))
        else $error("skip decision wrong");

    AST_ZERO_RESULT: assert property (
        ex_fire && (op == OP_COMPLEMENT_FILE_OP || op == OP_DECREMENT_FILE_OP) |=> o_zero == $past(res_zero))
        else $error("zero flag does not follow result");

    AST_ONE_CYCLE: assert property (
        ex_fire && op != OP_CALL |=> state == ST_IDLE && !o_busy)
        else $error("instruction not single cycle");

endmodule
`default_nettype wire

// file: design/file_reg_ram.sv
// File register storage, 128 bytes, one write port and two read ports.
// Read data are registered; all state freezes while the enable is low.
`timescale 1ns/1ps
`default_nettype none
module file_reg_ram
(
    input  wire logic       i_core_clk,
    input  wire logic       i_core_en,
    input  wire logic       i_we,
    input  wire logic [6:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [6:0] i_raddr_a,
    input  wire logic [6:0] i_raddr_b,
    output var  logic [7:0] o_rdata_a,
    output var  logic [7:0] o_rdata_b
);

    logic [7:0] mem [0:127];

    // No reset: contents are undefined until software or code writes them
    always_ff @(posedge i_core_clk)
    begin
        if (i_core_en)
        begin
            if (i_we)
            begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata_a <= mem[i_raddr_a];
            o_rdata_b <= mem[i_raddr_b];
        end
    end

endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the instruction-subset executor.
// Drives the AXI4-Lite register port and the watchdog/sleep event pulses.
`timescale 1ns/1ps
`default_nettype none
module tb
    import cpu_exec_pkg::*;
;
    logic              core_clk;
    logic              sys_rst;
    logic              core_en;
    logic              wdt_expired;
    logic              sleep_entered;
    logic              awvalid;
    logic              wvalid;
    logic              bready;
    logic              arvalid;
    logic              rready;
    logic [7:0]        awaddr;
    logic [7:0]        araddr;
    logic [31:0]       wdata;
    wire logic         awready;
    wire logic         wready;
    wire logic         bvalid;
    wire logic         arready;
    wire logic         rvalid;
    wire logic         wdt_clear;
    wire logic         stack_push;
    wire logic         zero;
    wire logic         to_n;
    wire logic         pd_n;
    wire logic         busy;
    wire logic [1:0]   bresp;
    wire logic [1:0]   rresp;
    wire logic [31:0]  rdata;
    wire logic [14:0]  stack_data;
    wire logic [14:0]  pc;
    wire logic [7:0]   w;
    logic [31:0]       rdv;
    logic [1:0]        last_resp;
    logic [14:0]       epc;
    int                mismatches;
    int                comparisons;
    int                n_wdt;
    int                n_push;

    cpu_instr_subset_exec i_cpu_instr_subset_exec (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_core_en(core_en),
        .i_wdt_expired(wdt_expired), .i_sleep_entered(sleep_entered),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .o_wdt_clear(wdt_clear), .o_stack_push(stack_push), .o_stack_data(stack_data),
        .o_pc(pc), .o_w(w), .o_zero(zero), .o_to_n(to_n), .o_pd_n(pd_n), .o_busy(busy));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Pulse counters, so a stuck-high strobe shows up as an extra count
    always @(posedge core_clk)
    begin
        if (wdt_clear === 1'b1) n_wdt++;
        if (stack_push === 1'b1) n_push++;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= d;
        bready  <= 1'b1;
        forever
        begin
            @(posedge core_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
            n++;
            if (n > 100)
            begin
                mismatches++;
                end_of_test();
            end
        end
        last_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        forever
        begin
            @(posedge core_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
            n++;
            if (n > 100)
            begin
                mismatches++;
                end_of_test();
            end
        end
        rdv = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask

    // Waits response plus settle time; a call lands on the fixed target below
    task automatic exec(input logic [5:0] opc, input logic d);
        wr(OFF_INSTR, {18'h0, opc, d, 7'h7F});
        repeat (5) @(posedge core_clk);
        epc = (opc == OPC_CALL) ? 15'h125A : epc + 15'h0001;
        chk(pc, epc);
        chk(busy, 1'b0);
    endtask

    task automatic fop(input logic [5:0] opc, input logic d, input logic [7:0] init,
                       input logic [7:0] ew, input logic [7:0] ef, input logic ez);
        wr(OFF_FDATA, {24'h0, init});
        exec(opc, d);
        rd(OFF_FDATA);
        chk(rdv, ef);
        chk(w, ew);
        chk(zero, ez);
    endtask

    initial
    begin
        sys_rst = 1'b1; wdt_expired = 1'b0; sleep_entered = 1'b0;
        core_en = 1'b1;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        mismatches = 0; comparisons = 0; n_wdt = 0; n_push = 0; epc = 15'h0000;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk({pc, w, zero, to_n, pd_n}, {15'h0, 8'h0, 3'h3});
        wdt_expired <= 1'b1;
        sleep_entered <= 1'b1;
        @(posedge core_clk);
        wdt_expired <= 1'b0;
        sleep_entered <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({to_n, pd_n}, 2'h0);
        exec(OPC_WDT, 1'b0);
        chk(n_wdt, 32'h1);
        chk({to_n, pd_n}, 2'h3);
        wr(OFF_FADDR, 32'h7F);
        fop(OPC_COMPLEMENT_FILE_OP, 1'b0, 8'hA5, 8'h5A, 8'hA5, 1'b0);
        fop(OPC_COMPLEMENT_FILE_OP, 1'b1, 8'h00, 8'h5A, 8'hFF, 1'b0);
        fop(OPC_COMPLEMENT_FILE_OP, 1'b1, 8'hFF, 8'h5A, 8'h00, 1'b1);
        fop(OPC_DECREMENT_FILE_OP, 1'b0, 8'h5A, 8'h59, 8'h5A, 1'b0);
        fop(OPC_DECREMENT_FILE_OP, 1'b1, 8'h01, 8'h59, 8'h00, 1'b1);
        fop(OPC_DECREMENT_FILE_OP, 1'b1, 8'h00, 8'h59, 8'hFF, 1'b0);
        fop(OPC_CLEAR_WORKING_REG_OP, 1'b0, 8'hFF, 8'h00, 8'hFF, 1'b1);
        fop(OPC_COMPLEMENT_FILE_OP, 1'b1, 8'h00, 8'h00, 8'hFF, 1'b0);
        fop(OPC_CLEAR_FILE_OP, 1'b1, 8'h77, 8'h00, 8'h00, 1'b1);
        rd(OFF_CYCLES);
        chk(rdv, 32'h1);
        // Zero stays set although a plain decrement would clear it
        fop(OPC_DSZ, 1'b1, 8'h02, 8'h00, 8'h01, 1'b1);
        wr(OFF_WREG, 32'h33);
        fop(OPC_DSZ, 1'b0, 8'h01, 8'h00, 8'h01, 1'b1);
        rd(OFF_CYCLES);
        chk(rdv, 32'h2);
        rd(OFF_STATUS);
        chk(rdv[ST_SKIP_BIT], 1'b1);
        // Discarded word: complement into W would give FE and clear zero
        fop(OPC_COMPLEMENT_FILE_OP, 1'b0, 8'h01, 8'h00, 8'h01, 1'b1);
        wr(OFF_WREG, 32'h5A);
        wr(OFF_PCH, 32'h12);
        chk(n_push, 32'h0);
        chk(stack_data, 15'h0000);
        // Thirteen words so far, the last one discarded, so PC is 0D
        exec(OPC_CALL, 1'b0);
        chk(n_push, 32'h1);
        chk(stack_data, 15'h000E);
        rd(OFF_TOS);
        chk(rdv, 32'hE);
        rd(OFF_CYCLES);
        chk(rdv, 32'h2);
        chk({zero, to_n, pd_n}, 3'h7);
        exec(OPC_CLEAR_WORKING_REG_OP, 1'b0);
        // Enable low: the accepted word must not run until it returns
        wr(OFF_INSTR, {18'h0, OPC_CLEAR_WORKING_REG_OP, 8'h7F});
        core_en <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk(pc, epc);
        core_en <= 1'b1;
        repeat (5) @(posedge core_clk);
        epc = epc + 15'h0001;
        chk({pc, busy}, {epc, 1'b0});
        // Undecoded opcode behaves as a no-op
        exec(6'h3F, 1'b0);
        chk(w, 32'h0);
        rd(8'h24);
        chk({last_resp, rdv}, {RESP_DECERR, 32'h0});
        wr(8'h40, 32'h1);
        chk(last_resp, RESP_DECERR);
        end_of_test();
    end

    // Hang guard, well past the expected run length
    initial
    begin
        #200000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
